// file: rtl/misb_top.sv
// Interrupt status registers 2 and 3 and configuration register 1 of the monitor.
// Assumes an internal register port from the serial slave and
// condition inputs from comparators and the processor-link engine, all on I_CLK.
`timescale 1ns/100ps
`include "misb_defines.svh"

module misb_top (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    input wire logic [7:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] I_WDATA,
    output logic [7:0] O_RDATA,
    input wire logic [7:0] I_V12_VALUE,
    input wire logic [7:0] I_V12_LOW_LIMIT,
    input wire logic [7:0] I_V12_HIGH_LIMIT,
    input wire logic [3:0] I_FAN_SLOW,
    input wire logic [2:0] I_PWM_ON,
    input wire logic I_FOURTH_SPEED_INPUT,
    input wire logic [1:0] I_DIODE_FAULT,
    input wire logic I_CPU_TEMP_OUT,
    input wire logic I_SENSOR_ERR,
    input wire logic [15:0] I_SENSOR_ERROR_CODE,
    input wire logic I_LINK_COMM_ERR,
    input wire logic I_OVERHEAT_TRIP,
    input wire logic I_OVERHEAT_RELEASED,
    input wire logic [7:0] I_BANK4_STATUS,
    output logic O_MONITOR_RUN,
    output logic O_USE_DEFAULT_LIMITS,
    output logic O_LOCKED,
    output logic O_PWM_FORCE_FULL,
    output logic [7:0] O_PWM_FULL_DUTY,
    output logic O_FAN_BOOST,
    output logic O_PECI_ENABLE,
    output logic O_OVERHEAT_OVERRIDE,
    output logic [1:0] O_AVERAGE_LENGTH
);

    // Sticky flag: an event sets; a read clears only once the cause is gone
    function automatic logic sticky(input logic cause, input logic flag, input logic rd);
        sticky = cause | (flag & ~rd);
    endfunction

    function automatic misb_pkg::misb_etype_t err_type(input misb_pkg::misb_code_t code);
        case (code)
            `MISB_PECI_GENERAL: err_type = `MISB_ETYPE_GENERAL;
            `MISB_PECI_UNDER: err_type = `MISB_ETYPE_UNDER;
            `MISB_PECI_OVER: err_type = `MISB_ETYPE_OVER;
            default: err_type = `MISB_ETYPE_OTHER;
        endcase
    endfunction

    logic monitor_run_ff;
    logic lock_ff;
    logic fan_boost_ff;
    logic peci_en_ff;
    logic ovr_ff;
    logic [1:0] avg_ff;
    logic [7:0] stat2_ff;
    logic [7:0] stat3_ff;
    logic [7:0] rdata_ff;

    logic cfg_wr;
    logic rd2;
    logic rd3;
    logic [7:0] eff_low;
    logic [7:0] eff_high;
    logic v12_cause;
    logic [3:0] fan_cause;
    logic ovt_cause;
    logic out_of_limit_summary;
    logic higher_bank_summary;
    misb_pkg::misb_byte_t stat2_view;
    misb_pkg::misb_byte_t stat3_view;
    misb_pkg::misb_byte_t cfg_view;
    misb_pkg::misb_byte_t nxt_stat2;
    misb_pkg::misb_byte_t nxt_stat3;
    misb_pkg::misb_byte_t nxt_rdata;

    assign cfg_wr = I_WR && (I_ADDR == `MISB_CFG1_ADDR);
    assign rd2 = I_RD && (I_ADDR == `MISB_STAT2_ADDR);
    assign rd3 = I_RD && (I_ADDR == `MISB_STAT3_ADDR);

    // Run bit ignores the lock
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            monitor_run_ff <= 1'b0;
        end else if (I_CE && cfg_wr) begin
            monitor_run_ff <= I_WDATA[`MISB_CFG1_RUN];
        end
    end

    // Lock is write-once; only reset releases it
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lock_ff <= 1'b0;
        end else if (I_CE && cfg_wr && I_WDATA[`MISB_CFG1_LOCK]) begin
            lock_ff <= 1'b1;
        end
    end

    // Boost stays writable after lock
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fan_boost_ff <= 1'b0;
        end else if (I_CE && cfg_wr) begin
            fan_boost_ff <= I_WDATA[`MISB_CFG1_BOOST];
        end
    end

    // Lockable configuration fields
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            peci_en_ff <= 1'b0;
            ovr_ff <= 1'b0;
            avg_ff <= 2'h0;
        end else if (I_CE && cfg_wr && !lock_ff) begin
            peci_en_ff <= I_WDATA[`MISB_CFG1_PECI_EN];
            ovr_ff <= I_WDATA[`MISB_CFG1_OVR];
            avg_ff <= I_WDATA[`MISB_CFG1_AVG_HI:`MISB_CFG1_AVG_LO];
        end
    end

    // Stopped monitor compares against power-up limits
    always_comb begin
        eff_low = monitor_run_ff ? I_V12_LOW_LIMIT : `MISB_DEF_LOW_LIMIT;
        eff_high = monitor_run_ff ? I_V12_HIGH_LIMIT : `MISB_DEF_HIGH_LIMIT;
    end

    assign v12_cause = (I_V12_VALUE > eff_high) || (I_V12_VALUE <= eff_low);

    // Stall flags are held off while the driving PWM is off
    assign fan_cause[0] = I_FAN_SLOW[0] && I_PWM_ON[0];
    assign fan_cause[1] = I_FAN_SLOW[1] && I_PWM_ON[1];
    assign fan_cause[2] = I_FAN_SLOW[2] && I_PWM_ON[2];
    assign fan_cause[3] = I_FAN_SLOW[3] && I_PWM_ON[2] && I_FOURTH_SPEED_INPUT;

    // Overtemp stays present until released below the hysteresis point
    assign ovt_cause = I_OVERHEAT_TRIP || (stat3_ff[`MISB_S3_OVT] && !I_OVERHEAT_RELEASED);

    // Summaries from live register contents
    assign higher_bank_summary = |I_BANK4_STATUS;
    assign out_of_limit_summary = |stat3_view;

    always_comb begin
        stat3_view = stat3_ff;
        stat3_view[`MISB_S3_SUM] = higher_bank_summary;
        stat2_view = stat2_ff;
        stat2_view[`MISB_S2_SUM] = out_of_limit_summary;
    end

    always_comb begin
        cfg_view = 8'h00;
        cfg_view[`MISB_CFG1_RUN] = monitor_run_ff;
        cfg_view[`MISB_CFG1_LOCK] = lock_ff;
        cfg_view[`MISB_CFG1_READY] = 1'b1;
        cfg_view[`MISB_CFG1_BOOST] = fan_boost_ff;
        cfg_view[`MISB_CFG1_PECI_EN] = peci_en_ff;
        cfg_view[`MISB_CFG1_OVR] = ovr_ff;
        cfg_view[`MISB_CFG1_AVG_HI:`MISB_CFG1_AVG_LO] = avg_ff;
    end

    always_comb begin
        nxt_stat2 = stat2_ff;
        nxt_stat2[`MISB_S2_V12] = sticky(v12_cause, stat2_ff[`MISB_S2_V12], rd2);
        nxt_stat2[`MISB_S2_SUM] = 1'b0;
        for (int i = 0; i < 4; i++) begin
            nxt_stat2[`MISB_S2_FIRST_FAN_STALL + i] = sticky(fan_cause[i], stat2_ff[`MISB_S2_FIRST_FAN_STALL + i], rd2);
        end
        nxt_stat2[`MISB_S2_D1] = sticky(I_DIODE_FAULT[0], stat2_ff[`MISB_S2_D1], rd2);
        nxt_stat2[`MISB_S2_D2] = sticky(I_DIODE_FAULT[1], stat2_ff[`MISB_S2_D2], rd2);
    end

    always_comb begin
        nxt_stat3 = stat3_ff;
        nxt_stat3[`MISB_S3_CPU] = sticky(I_CPU_TEMP_OUT, stat3_ff[`MISB_S3_CPU], rd3);
        nxt_stat3[`MISB_S3_DATA] = sticky(I_SENSOR_ERR, stat3_ff[`MISB_S3_DATA], rd3);
        nxt_stat3[`MISB_S3_COMM] = sticky(I_LINK_COMM_ERR, stat3_ff[`MISB_S3_COMM], rd3);
        nxt_stat3[`MISB_S3_OVT] = sticky(ovt_cause, stat3_ff[`MISB_S3_OVT], rd3);
        if (I_SENSOR_ERR) begin
            nxt_stat3[6:4] = err_type(I_SENSOR_ERROR_CODE);
        end else if (!nxt_stat3[`MISB_S3_DATA]) begin
            nxt_stat3[6:4] = 3'h0;
        end
        nxt_stat3[`MISB_S3_SUM] = 1'b0;
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            stat2_ff <= `MISB_STAT_RESET;
        end else if (I_CE) begin
            stat2_ff <= nxt_stat2;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            stat3_ff <= `MISB_STAT_RESET;
        end else if (I_CE) begin
            stat3_ff <= nxt_stat3;
        end
    end

    // Read data shows contents before the read clears them
    always_comb begin
        case (I_ADDR)
            `MISB_CFG1_ADDR: nxt_rdata = cfg_view;
            `MISB_STAT2_ADDR: nxt_rdata = stat2_view;
            `MISB_STAT3_ADDR: nxt_rdata = stat3_view;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_ff <= 8'h00;
        end else if (I_CE && I_RD) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign O_RDATA = rdata_ff;
    assign O_MONITOR_RUN = monitor_run_ff;
    assign O_USE_DEFAULT_LIMITS = !monitor_run_ff;
    assign O_LOCKED = lock_ff;
    assign O_PWM_FORCE_FULL = !monitor_run_ff || fan_boost_ff;
    assign O_PWM_FULL_DUTY = `MISB_PWM_FULL_DUTY;
    assign O_FAN_BOOST = fan_boost_ff;
    assign O_PECI_ENABLE = peci_en_ff;
    assign O_OVERHEAT_OVERRIDE = ovr_ff;
    assign O_AVERAGE_LENGTH = avg_ff;

endmodule

// file: rtl/misb_defines.svh
// Offsets, field positions, reset values and error codes of the status bank.
// Included by the bank; the checker and testbench decode its registers with literal values instead.
`ifndef MISB_DEFINES_SVH
`define MISB_DEFINES_SVH

`define MISB_CFG1_ADDR 8'h40
`define MISB_STAT2_ADDR 8'h42
`define MISB_STAT3_ADDR 8'h43

`define MISB_CFG1_RESET 8'h00
`define MISB_STAT_RESET 8'h00

`define MISB_CFG1_RUN 0
`define MISB_CFG1_LOCK 1
`define MISB_CFG1_READY 2
`define MISB_CFG1_BOOST 3
`define MISB_CFG1_PECI_EN 4
`define MISB_CFG1_OVR 5
`define MISB_CFG1_AVG_LO 6
`define MISB_CFG1_AVG_HI 7

`define MISB_S2_V12 0
`define MISB_S2_SUM 1
`define MISB_S2_FIRST_FAN_STALL 2
`define MISB_S2_FOURTH_FAN_STALL 5
`define MISB_S2_D1 6
`define MISB_S2_D2 7

`define MISB_S3_CPU 0
`define MISB_S3_DATA 1
`define MISB_S3_COMM 2
`define MISB_S3_OVT 3
`define MISB_S3_SUM 7

`define MISB_PECI_GENERAL 16'h8000
`define MISB_PECI_UNDER 16'h8002
`define MISB_PECI_OVER 16'h8003
`define MISB_ETYPE_GENERAL 3'h0
`define MISB_ETYPE_UNDER 3'h1
`define MISB_ETYPE_OVER 3'h2
`define MISB_ETYPE_OTHER 3'h7

`define MISB_DEF_LOW_LIMIT 8'h00
`define MISB_DEF_HIGH_LIMIT 8'hFF

`define MISB_PWM_FULL_DUTY 8'hFF

`endif

// file: rtl/misb_pkg.sv
// Types shared by the monitor status bank.
// No timing assumptions; holds type definitions only.
package misb_pkg;

    typedef logic [7:0] misb_byte_t;
    typedef logic [15:0] misb_code_t;
    typedef logic [2:0] misb_etype_t;

endpackage

// file: sim/misb_checker.sv
// Checker: port-level assertions for the status bank.
// Bound into misb_top; one clock, async active-low reset.
`timescale 1ns/100ps
module misb_checker (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    input wire logic [7:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] I_WDATA,
    input wire logic [7:0] O_RDATA,
    input wire logic [7:0] I_V12_VALUE,
    input wire logic [7:0] I_V12_LOW_LIMIT,
    input wire logic [7:0] I_V12_HIGH_LIMIT,
    input wire logic [7:0] I_BANK4_STATUS,
    input wire logic O_MONITOR_RUN,
    input wire logic O_USE_DEFAULT_LIMITS,
    input wire logic O_LOCKED,
    input wire logic O_PWM_FORCE_FULL,
    input wire logic [7:0] O_PWM_FULL_DUTY,
    input wire logic O_PECI_ENABLE
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    wire rd2 = I_CE && I_RD && I_ADDR == 8'h42;
    wire rd3 = I_CE && I_RD && I_ADDR == 8'h43;
    wire b4any = |I_BANK4_STATUS;
    wire v12hl = I_V12_VALUE > I_V12_HIGH_LIMIT || I_V12_VALUE <= I_V12_LOW_LIMIT;
    wire v12c = O_MONITOR_RUN ? v12hl : I_V12_VALUE == 8'h00;
    AST_FULL: assert property (!O_MONITOR_RUN |-> O_PWM_FORCE_FULL && O_PWM_FULL_DUTY == 8'hFF)
        else $error("fans not full");
    AST_DEFLIM: assert property (O_USE_DEFAULT_LIMITS == !O_MONITOR_RUN)
        else $error("limit select wrong");
    AST_RUN_WR: assert property (I_CE && I_WR && I_ADDR == 8'h40 |=> O_MONITOR_RUN == $past(I_WDATA[0]))
        else $error("run bit not written");
    AST_LOCK: assert property (O_LOCKED |=> O_LOCKED && $stable(O_PECI_ENABLE))
        else $error("lock not held");
    AST_V12_SET: assert property (v12c && I_CE ##1 rd2 && v12c |=> O_RDATA[0])
        else $error("12 V flag not set");
    AST_KEEP: assert property (rd2 && v12c ##2 rd2 |=> O_RDATA[0])
        else $error("flag lost while cause present");
    AST_V12_CLR: assert property (rd2 && !v12c ##1 !v12c ##1 rd2 && !v12c |=> !O_RDATA[0])
        else $error("12 V flag not cleared");
    AST_SUM3: assert property (rd3 |=> O_RDATA[7] == $past(b4any))
        else $error("bank 4 summary wrong");
    AST_SUM2: assert property (rd2 && b4any |=> O_RDATA[1])
        else $error("bank 3 summary wrong");
    cover property (rd2 && v12c);
    cover property (rd3 && b4any);
    cover property (O_LOCKED && !O_MONITOR_RUN);
endmodule
bind misb_top misb_checker u_misb_checker (.*);

// file: sim/misb_host.sv
// Host model: register reads and writes on the bank port.
// Drives on the falling edge; one-cycle strobes.
`timescale 1ns/100ps
module misb_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic o_ce = 1'b1,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00,
    output logic o_rd = 1'b0,
    output logic o_wr = 1'b0
);
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
    endtask
endmodule

// file: sim/monitor_interrupt_status_bank_tb_top.sv
// Testbench: drives monitor events, checks status reads.
// Host model gives register access; checker attached by bind.
`timescale 1ns/100ps
module monitor_interrupt_status_bank_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] v12 = 8'hF0;
    logic [7:0] b4 = 8'h00;
    logic [3:0] slow = 4'h0;
    logic [2:0] pwm = 3'h0;
    logic [1:0] diode = 2'h0;
    logic [15:0] code = 16'h0000;
    logic fourth = 1'b0, cpu = 1'b0, serr = 1'b0, comm = 1'b0, trip = 1'b0, rel = 1'b0;
    logic [15:0] codes [4] = '{16'h8000, 16'h8002, 16'h8003, 16'h1234};
    logic [7:0] e43 [4] = '{8'h02, 8'h12, 8'h22, 8'h72};
    wire logic ce, rd, wr, run, ffull, deflim;
    wire logic [7:0] addr, wdata, rdata;
    int fail_count = 0, n_compared = 0, cyc = 0;
    always #5 clk = ~clk;
    misb_host u_misb_host (.i_clk(clk), .i_rdata(rdata), .o_ce(ce), .o_addr(addr), .o_wdata(wdata),
        .o_rd(rd), .o_wr(wr));
    misb_top u_misb_top (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_WDATA(wdata), .O_RDATA(rdata), .I_V12_VALUE(v12), .I_V12_LOW_LIMIT(8'h10), .I_V12_HIGH_LIMIT(8'hF0),
        .I_FAN_SLOW(slow), .I_PWM_ON(pwm), .I_FOURTH_SPEED_INPUT(fourth), .I_DIODE_FAULT(diode),
        .I_CPU_TEMP_OUT(cpu), .I_SENSOR_ERR(serr), .I_SENSOR_ERROR_CODE(code), .I_LINK_COMM_ERR(comm),
        .I_OVERHEAT_TRIP(trip), .I_OVERHEAT_RELEASED(rel), .I_BANK4_STATUS(b4), .O_MONITOR_RUN(run),
        .O_USE_DEFAULT_LIMITS(deflim), .O_LOCKED(), .O_PWM_FORCE_FULL(ffull), .O_PWM_FULL_DUTY(),
        .O_FAN_BOOST(), .O_PECI_ENABLE(), .O_OVERHEAT_OVERRIDE(), .O_AVERAGE_LENGTH());
    task automatic conclude();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_misb_host.read_reg(a, d);
        cmp(d, exp);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        cmp({7'h00, ffull}, 8'h01);
        chk(8'h42, 8'h00);
        chk(8'h43, 8'h00);
        u_misb_host.write_reg(8'h40, 8'h13);
        chk(8'h40, 8'h17);
        u_misb_host.write_reg(8'h40, 8'h00);
        chk(8'h40, 8'h16);
        cmp({6'h00, ffull, deflim}, 8'h03);
        u_misb_host.write_reg(8'h40, 8'h01);
        cmp({6'h00, ffull, deflim}, 8'h00);
        chk(8'h42, 8'h00);
        v12 = 8'hF1;
        chk(8'h42, 8'h01);
        chk(8'h42, 8'h01);
        v12 = 8'h10;
        chk(8'h42, 8'h01);
        v12 = 8'h11;
        chk(8'h42, 8'h01);
        chk(8'h42, 8'h00);
        slow = 4'hF;
        fourth = 1'b1;
        pwm = 3'h3;
        chk(8'h42, 8'h0C);
        pwm = 3'h7;
        diode = 2'h3;
        chk(8'h42, 8'hFC);
        slow = 4'h0;
        diode = 2'h0;
        chk(8'h42, 8'hFC);
        for (int i = 0; i < 4; i++) begin
            code = codes[i];
            serr = 1'b1;
            @(negedge clk);
            serr = 1'b0;
            chk(8'h42, 8'h02);
            chk(8'h43, e43[i]);
            chk(8'h43, 8'h00);
        end
        comm = 1'b1;
        cpu = 1'b1;
        @(negedge clk);
        comm = 1'b0;
        chk(8'h43, 8'h05);
        cpu = 1'b0;
        chk(8'h43, 8'h01);
        trip = 1'b1;
        @(negedge clk);
        trip = 1'b0;
        chk(8'h43, 8'h08);
        rel = 1'b1;
        chk(8'h43, 8'h08);
        b4 = 8'h10;
        chk(8'h43, 8'h80);
        chk(8'h42, 8'h02);
        b4 = 8'h00;
        chk(8'h42, 8'h00);
        chk(8'h7F, 8'h00);
        conclude();
    end
endmodule
